// >>> core/sss_top.sv
/*
 safe standstill input logic: two redundant shutdown channels gate the
 power stage enable, latch an error, and block restart until reset.
 assumes synchronous inputs on one 100 MHz clock and that the motion
 controller honours the drive enable it is given.
*/
`timescale 1ns/100ps
`include "sss_params.svh"
module sss_top #(
   parameter int FILT_CYC = `SSS_FILT_CYC,
   parameter int SKEW_CYC = `SSS_SKEW_CYC
) (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RST_B,
   // shutdown inputs, high allows running
   input wire logic I_SHDN_A,
   input wire logic I_SHDN_B,
   // controller side
   input wire logic I_RUN_REQ,
   input wire logic I_ERR_RESET,
   // power stage
   output logic O_STAGE_EN,
   output logic O_BRAKE_EN,
   // status
   output logic O_ERROR,
   output sss_pkg::sss_status_t O_STATUS
);
   // width of the discrepancy timer
   localparam int SW = $clog2(SKEW_CYC + 1);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // refuse settings that would break the response limit or the timer
   if (FILT_CYC + 2 >= `SSS_RESP_CYC) begin : g_bad_resp
      $error("filter too long for the response limit");
   end
   if (SKEW_CYC < 1) begin : g_bad_skew
      $error("skew limit must be at least one cycle");
   end

   // ----------------------------------------
   // channel filters
   // ----------------------------------------
   logic [1:0] lvl;
   logic [1:0] off;
   // channel levels, bit 0 is channel a
   assign lvl = {I_SHDN_B, I_SHDN_A};

   // one filter per channel, independent paths; the filters start in the
   // off state, so every power-up passes through the fault state and
   // needs an explicit error reset before motion can resume
   for (genvar g = 0; g < 2; g++) begin : g_chan
      sss_filter #(
         .FILT_CYC(FILT_CYC)
      ) u_filt (
         .i_clk(I_SYS_CLK),
         .i_rst_b(I_RST_B),
         .i_level(lvl[g]),
         .o_off(off[g])
      );
   end

   // ----------------------------------------
   // channel discrepancy timer
   // ----------------------------------------
   logic [SW-1:0] skew_ff;
   logic [SW-1:0] nxt_skew;
   logic disc_ff;
   logic nxt_disc;

   // counts while the channels disagree; beyond the limit it is a fault
   // the flag drops only once both channels agree and the error reset is
   // given, so a fault exit always needs a reset after the agreement
   always_comb begin
      nxt_skew = '0;
      nxt_disc = disc_ff;
      if (off[0] != off[1]) begin
         if (skew_ff >= SW'(SKEW_CYC - 1)) begin
            nxt_disc = 1'b1;
            nxt_skew = skew_ff;
         end else begin
            nxt_skew = skew_ff + SW'(1);
         end
      end else if (I_ERR_RESET) begin
         nxt_disc = 1'b0;
      end
   end

   // discrepancy registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         skew_ff <= '0;
         disc_ff <= 1'b0;
      end else begin
         skew_ff <= nxt_skew;
         disc_ff <= nxt_disc;
      end
   end

   // ----------------------------------------
   // standstill state machine
   // ----------------------------------------
   sss_pkg::sss_state_t state_ff;
   sss_pkg::sss_state_t nxt_state;
   logic any_off;
   logic stage_ff;
   logic nxt_stage;
   logic err_ff;
   logic nxt_err;
   // either filtered channel off is a shutdown request
   assign any_off = off[0] | off[1];

   // shutdown wins over reset and run in the same cycle
   // the filters already absorb test pulses, so a filtered shutdown
   // moves stop and run to the fault state with no further delay
   always_comb begin
      nxt_state = state_ff;
      nxt_err = err_ff;
      case (state_ff)
         sss_pkg::SSS_STOP: begin
            // start as soon as the run request is high; a request held through reset is not enough, as the off filters force the fault state first
            if (any_off) begin
               nxt_state = sss_pkg::SSS_FAULT;
               nxt_err = 1'b1;
            end else if (I_RUN_REQ) begin
               nxt_state = sss_pkg::SSS_RUN;
            end
         end
         sss_pkg::SSS_RUN: begin
            if (any_off) begin
               nxt_state = sss_pkg::SSS_FAULT;
               nxt_err = 1'b1;
            end else if (!I_RUN_REQ) begin
               nxt_state = sss_pkg::SSS_STOP;
            end
         end
         sss_pkg::SSS_FAULT: begin
            // leave only on explicit reset with both channels on
            // and no discrepancy flagged; a run request still held then starts from stop
            if (I_ERR_RESET && !any_off && !disc_ff) begin
               nxt_state = sss_pkg::SSS_STOP;
               nxt_err = 1'b0;
            end
         end
         default: begin
            // an unknown state code is treated as a shutdown
            nxt_state = sss_pkg::SSS_FAULT;
            nxt_err = 1'b1;
         end
      endcase
      // stage enable follows the next state, registered once, so it
      // drops on the same edge that latches the error
      nxt_stage = (nxt_state == sss_pkg::SSS_RUN) && !any_off;
   end

   // state registers; reset lands in stop with the error clear and the
   // power stage off, and the off filters then force the fault state
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         state_ff <= sss_pkg::SSS_STOP;
         err_ff <= 1'b0;
         stage_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         err_ff <= nxt_err;
         stage_ff <= nxt_stage;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   sss_pkg::sss_status_t status_ff;
   sss_pkg::sss_status_t nxt_status;
   logic brake_ff;
   logic nxt_brake;

   // status mirror, one cycle behind the internal state; the error bit
   // also shows a discrepancy so the controller sees either cause
   always_comb begin
      nxt_status = '0;
      nxt_status.error = err_ff | disc_ff;
      nxt_status.discrepancy = disc_ff;
      nxt_status.chan_a_off = off[0];
      nxt_status.chan_b_off = off[1];
   end

   // brake request: held off at all times so a stopped motor coasts
   always_comb begin
      nxt_brake = 1'b0;
   end

   // output registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         status_ff <= '0;
         brake_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         brake_ff <= nxt_brake;
      end
   end

   // every output comes straight from a register
   assign O_STAGE_EN = stage_ff;
   assign O_BRAKE_EN = brake_ff;
   assign O_ERROR = err_ff;
   assign O_STATUS = status_ff;
endmodule : sss_top

// >>> core/sss_params.svh
/*
 constants for the safe standstill input logic: timing figures and counts.
 assumes a 100 MHz system clock; included by bare name.
*/
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
`define SSS_CLK_MHZ 100
// longest test pulse that must be tolerated, in microseconds
`define SSS_PULSE_US 1000
// longest time from shutdown request to output stage off, in microseconds
`define SSS_RESP_US 50000
// tolerated pulse as cycles
`define SSS_PULSE_CYC (`SSS_PULSE_US * `SSS_CLK_MHZ)
// filter length: pulse width plus a margin of a quarter of it
`define SSS_FILT_CYC (`SSS_PULSE_CYC + (`SSS_PULSE_CYC / 4))
// response limit as cycles, rounded down
`define SSS_RESP_CYC (`SSS_RESP_US * `SSS_CLK_MHZ)
// skew allowed between the two channels, in microseconds
`define SSS_SKEW_US 1000000
`define SSS_SKEW_CYC (`SSS_SKEW_US * `SSS_CLK_MHZ)
`endif

// >>> core/sss_pkg.sv
/*
 types for the safe standstill input logic.
 assumes nothing of its surroundings.
*/
package sss_pkg;
   // drive state
   typedef enum logic [1:0] {
      SSS_RUN,
      SSS_STOP,
      SSS_FAULT
   } sss_state_t;
   // status word toward the motion controller
   typedef struct packed {
      logic error;
      logic discrepancy;
      logic chan_a_off;
      logic chan_b_off;
   } sss_status_t;
endpackage : sss_pkg

// >>> core/sss_filter.sv
/*
 one shutdown channel filter: reset sets it off; after that a low level must persist
 for the full filter length before the channel counts as off; a return high clears it.
 assumes the input is synchronous to the clock.
*/
`timescale 1ns/100ps
`include "sss_params.svh"
module sss_filter #(
   parameter int FILT_CYC = `SSS_FILT_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // channel
   input wire logic i_level,
   output logic o_off
);
   localparam int CW = $clog2(FILT_CYC + 1);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic off_ff;
   logic nxt_off;

   // elaboration check: a filter needs at least one cycle
   if (FILT_CYC < 1) begin : g_bad_filt
      $error("filter length must be at least one cycle");
   end

   // ----------------------------------------
   // low-level persistence counter
   // ----------------------------------------
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_off = off_ff;
      if (i_level) begin
         nxt_cnt = '0;
         nxt_off = 1'b0;
      end else if (cnt_ff >= CW'(FILT_CYC - 1)) begin
         nxt_off = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + CW'(1);
      end
   end

   // registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_ff <= '0;
         off_ff <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         off_ff <= nxt_off;
      end
   end

   assign o_off = off_ff;
endmodule : sss_filter

// >>> bench/sss_estop_model.sv
/* emergency stop module and master model for the drive inputs.
   assumes the bench drives its requests on the rising edge. */
`timescale 1ns/100ps
module sss_estop_model #(
   parameter int DELAY = 6
) (
   // clock
   input wire logic i_clk,
   // bench requests
   input wire logic i_trip,
   input wire logic i_run,
   input wire logic i_test_a,
   input wire logic i_test_b,
   // toward the drive
   output logic o_shdn_a,
   output logic o_shdn_b,
   output logic o_run_req
);
   int cnt = 0;
   // delay timer runs while the stop is tripped
   always @(posedge i_clk) cnt <= i_trip ? cnt + 1 : 0;
   wire cut = i_trip && cnt >= DELAY;
   // one cut drops both channels together
   assign o_shdn_a = !(cut || i_test_a);
   assign o_shdn_b = !(cut || i_test_b);
   // quick stop requested at once on a trip
   assign o_run_req = i_run && !i_trip;
endmodule : sss_estop_model

// >>> bench/sss_top_checker.sv
/* port checker for the safe standstill top.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module sss_top_checker #(
   parameter int FILT_CYC = 8
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST_B,
   input wire logic I_SHDN_A,
   input wire logic I_SHDN_B,
   input wire logic I_RUN_REQ,
   input wire logic I_ERR_RESET,
   input wire logic O_STAGE_EN,
   input wire logic O_ERROR
);
   int lo_a;
   int lo_b;
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_B);
   // length of the current low run on each channel
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RST_B) begin
         lo_a <= 0;
         lo_b <= 0;
      end else begin
         lo_a <= I_SHDN_A ? 0 : lo_a + 1;
         lo_b <= I_SHDN_B ? 0 : lo_b + 1;
      end
   end
   cut_chan_a_a: assert property (lo_a > FILT_CYC + 3 |->
      !O_STAGE_EN && O_ERROR) else $error("channel a not cut");
   cut_chan_b_a: assert property (lo_b > FILT_CYC + 3 |->
      !O_STAGE_EN && O_ERROR) else $error("channel b not cut");
   pulse_pass_a: assert property (O_STAGE_EN && I_RUN_REQ &&
      lo_a < FILT_CYC && lo_b < FILT_CYC |=> O_STAGE_EN)
      else $error("short pulse stopped the drive");
   error_blocks_a: assert property (O_ERROR |-> !O_STAGE_EN)
      else $error("stage on with error");
   clear_cause_a: assert property ($fell(O_ERROR) |->
      $past(I_ERR_RESET && I_SHDN_A && I_SHDN_B))
      else $error("error cleared without reset");
   power_up_a: assert property ($rose(I_RST_B) |-> !O_STAGE_EN[*3])
      else $error("restart after power up");
   start_needs_a: assert property ($rose(O_STAGE_EN) |->
      $past(I_SHDN_A && I_SHDN_B && I_RUN_REQ))
      else $error("stage on without permission");
   quick_stop_a: assert property ($fell(I_RUN_REQ) && !O_ERROR &&
      I_SHDN_A && I_SHDN_B |-> ##[1:2] !O_STAGE_EN && !O_ERROR)
      else $error("quick stop wrong");
   cover property ($rose(O_STAGE_EN));
   cover property ($rose(O_ERROR));
   cover property ($fell(O_ERROR));
   cover property (!I_SHDN_A ##1 I_SHDN_A && O_STAGE_EN);
endmodule : sss_top_checker
bind sss_top sss_top_checker #(.FILT_CYC(FILT_CYC)) i_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_SHDN_A(I_SHDN_A),
   .I_SHDN_B(I_SHDN_B), .I_RUN_REQ(I_RUN_REQ),
   .I_ERR_RESET(I_ERR_RESET), .O_STAGE_EN(O_STAGE_EN),
   .O_ERROR(O_ERROR));

// >>> bench/sss_top_test.sv
/* bench for the safe standstill top: power up, pulse table, then held reset,
   trip and power-up cases. assumes short filter and skew counts. */
`timescale 1ns/100ps
module sss_top_test;
   typedef struct {int a; int b; logic e;} sss_row_t;
   sss_row_t rows[5] = '{'{7,0,0}, '{0,7,0}, '{12,0,1}, '{0,12,1},
      '{12,12,1}};
   logic clk = 0, rst_b = 0, err_rst = 0, run = 0, trip = 0;
   logic ta = 0, tb = 0, sa, sb, rq, st, bk, er;
   sss_pkg::sss_status_t stat;
   int num_errors = 0, total_checks = 0;
   always #5 clk = ~clk;
   sss_estop_model #(.DELAY(6)) i_em (.i_clk(clk), .i_trip(trip),
      .i_run(run), .i_test_a(ta), .i_test_b(tb), .o_shdn_a(sa),
      .o_shdn_b(sb), .o_run_req(rq));
   sss_top #(.FILT_CYC(8), .SKEW_CYC(20)) i_dut (.I_SYS_CLK(clk),
      .I_RST_B(rst_b), .I_SHDN_A(sa), .I_SHDN_B(sb), .I_RUN_REQ(rq),
      .I_ERR_RESET(err_rst), .O_STAGE_EN(st), .O_BRAKE_EN(bk),
      .O_ERROR(er), .O_STATUS(stat));
   task chk(string n, logic [3:0] e, logic [3:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task tick(int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // wait for the falling edge so outputs launched on the last rising
   // edge have settled before they are compared
   task look;
      @(negedge clk);
   endtask : look
   // clear the latched error and ask for motion in the same cycle
   task start;
      tick(1);
      err_rst <= 1;
      run <= 1;
      tick(1);
      err_rst <= 0;
      tick(3);
      look();
      chk("stage on", 4'h1, st);
   endtask : start
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   initial begin
      tick(20);
      rst_b <= 1;
      tick(3);
      look();
      chk("power up", 4'h0, st);
      chk("power up error", 4'h1, er);
      $display("power up done");
      foreach (rows[i]) begin
         start();
         for (int k = 0; k < 16; k++) begin
            tick(1);
            ta <= k < rows[i].a;
            tb <= k < rows[i].b;
         end
         tick(2);
         look();
         chk("error", rows[i].e, er);
         chk("stage", !rows[i].e, st);
         chk("status err", rows[i].e, stat.error);
         chk("status", {rows[i].e, 3'h0}, stat);
         chk("brake", 4'h0, bk);
         $display("row %0d done", i);
      end
      // channel a held off past the skew limit: discrepancy flagged and
      // error reset refused while the channel stays off
      tick(1);
      ta <= 1;
      tick(30);
      err_rst <= 1;
      look();
      chk("held status", 4'hE, stat);
      tick(1);
      err_rst <= 0;
      tick(2);
      look();
      chk("held error", 4'h1, er);
      // channels agree again: the first reset clears only the discrepancy
      tick(1);
      ta <= 0;
      tick(2);
      err_rst <= 1;
      tick(1);
      err_rst <= 0;
      tick(2);
      look();
      chk("disc reset error", 4'h1, er);
      chk("disc reset status", 4'h8, stat);
      $display("held reset done");
      // trip: quick stop first, channels drop after the delay
      start();
      tick(1);
      trip <= 1;
      tick(3);
      look();
      chk("quick stop", 4'h0, st);
      chk("no error yet", 4'h0, er);
      tick(16);
      look();
      chk("trip error", 4'h1, er);
      chk("trip status", 4'hB, stat);
      $display("trip done");
      // second power up with motion still requested
      tick(1);
      trip <= 0;
      rst_b <= 0;
      tick(3);
      rst_b <= 1;
      tick(4);
      look();
      chk("no restart", 4'h0, st);
      chk("restart error", 4'h1, er);
      $display("second power up done");
      wrap_up();
   end
   // watchdog well beyond the expected run length
   initial begin
      #20000;
      num_errors++;
      wrap_up();
   end
endmodule : sss_top_test
